// ---- rtl/ctf_pkg.sv ----
// Shared constants, register map and types for the camera trigger block.
// Functional notes
// - Free-run makes own timing, repeats exposure and output.
// - Trigger mode: exposure starts only on trigger.
// - Edge mode: exposure lasts programmed shutter time.
// - Width mode: expose while trigger stays active.
// - Sixteen stored settings stepped; mode off/bulk/sequential.
// - Bulk: one trigger, full run; sequential: one each.
// - Special: next exposure waits for output end.
// - Special active: no trigger mode, defect correction off.
// - Special source codes map to inputs, lines, software.
// - Special source and polarity separate; 0 negative.
// - Inhibit set: every trigger ignored.
// - Programmable trigger delay up to four seconds.
// - Trigger tally counts accepted, clears, wraps.
// - Image tally counts outputs, clears, wraps.
// - Width filter rejects short triggers, no output.
// - Filtered trigger starts exposure after lower limit.
// - Software trigger bypasses width filter.
// - Auto rate overlaps exposure with output.
// - Long shutter lowers frame rate.
// - Specified rate scaled by million, range checked.
// - Gain rises only after shutter reaches limit.
// - Brightness target fourteen bits, default 11264.
// - Shutter time in microseconds, 10 to 60000000.
package ctf_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC = 8'h04;
  localparam logic [7:0] OFS_SHUTTER = 8'h08;
  localparam logic [7:0] OFS_DELAY = 8'h0c;
  localparam logic [7:0] OFS_WIDTH_MIN = 8'h10;
  localparam logic [7:0] OFS_RATE = 8'h14;
  localparam logic [7:0] OFS_MSC_COUNT = 8'h18;
  localparam logic [7:0] OFS_SOFT = 8'h1c;
  localparam logic [7:0] OFS_TRIG_TALLY = 8'h20;
  localparam logic [7:0] OFS_FRAME_TALLY = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_TARGET = 8'h2c;
  localparam logic [7:0] OFS_READOUT = 8'h30;
  localparam logic [7:0] OFS_GAIN = 8'h34;
  localparam logic [7:0] OFS_TABLE = 8'h40;

  localparam int B_ACQ = 0;
  localparam int B_EXPSRC = 1;
  localparam int B_MSC_LO = 2;
  localparam int B_INH = 4;
  localparam int B_FILT = 5;
  localparam int B_AUTO = 6;
  localparam int B_POL = 7;
  localparam int B_MSC_POL = 8;
  localparam int B_DEFECT = 9;
  localparam int B_CGAIN = 10;
  localparam int B_CEXP = 11;
  localparam logic [11:0] CTRL_RST = 12'h040;

  localparam logic [7:0] SRC_SOFT = 8'h00;
  localparam logic [7:0] SRC_IN1 = 8'h04;
  localparam logic [7:0] SRC_IN3 = 8'h07;
  localparam logic [7:0] SRC_IN4 = 8'h0a;
  localparam logic [7:0] SRC_IN2 = 8'h0b;
  localparam logic [7:0] SRC_OR = 8'h14;
  localparam logic [7:0] SRC_CC1 = 8'h65;
  localparam logic [7:0] SRC_CC2 = 8'h66;
  localparam logic [7:0] SRC_CC3 = 8'h67;
  localparam logic [7:0] SRC_CC4 = 8'h68;
  localparam logic [7:0] SRC_RST = SRC_IN2;

  localparam logic [31:0] SHUTTER_MIN = 32'h0000000a;
  localparam logic [31:0] SHUTTER_MAX = 32'h03938700;
  localparam logic [31:0] SHUTTER_RST = 32'h00002710;
  localparam logic [31:0] DELAY_MAX = 32'h003d0900;
  localparam logic [31:0] WIDTH_MIN_LO = 32'h00000001;
  localparam logic [31:0] WIDTH_MIN_HI = 32'h001e8480;
  localparam logic [31:0] RATE_MIN = 32'h0000f424;
  localparam logic [31:0] RATE_RST = 32'h01c9c380;
  localparam logic [40:0] RATE_FULL = 41'h0e8d4a51000;
  localparam logic [31:0] TALLY_MAX = 32'h7fffffff;
  localparam logic [13:0] TARGET_RST = 14'h2c00;
  localparam logic [31:0] READOUT_RST = 32'h00002710;
  localparam logic [4:0] MSC_MAX = 5'h10;
  localparam logic [7:0] GAIN_MAX = 8'hff;

  typedef enum logic [1:0] {
    MSC_OFF = 2'h0,
    MSC_BULK = 2'h1,
    MSC_SEQ = 2'h2
  } ctf_msc_e;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_DELAY = 2'b01,
    TS_EXPOSE = 2'b11,
    TS_READOUT = 2'b10
  } ctf_state_e;
endpackage : ctf_pkg

// ---- rtl/ctf_trig_if.sv ----
// Link between the sequencer and the trigger front end.
interface ctf_trig_if;
  logic [7:0] src;
  logic pol;
  logic filt_en;
  logic [31:0] width_min;
  logic us_tick;
  logic level;
  logic fire;
  modport seq (output src, pol, filt_en, width_min, us_tick,
               input level, fire);
  modport front (input src, pol, filt_en, width_min, us_tick,
                 output level, fire);
endinterface : ctf_trig_if

// ---- rtl/ctf_trig_front.sv ----
// Trigger front end: pin sync, source select, polarity and width filter.
module ctf_trig_front
  import ctf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] gpi_raw,
  input wire logic [3:0] cc_raw,
  input wire logic soft_pulse,
  ctf_trig_if.front tif
);
  logic [7:0] meta_q;
  logic [7:0] sync_q;
  logic sel_raw;
  logic act;
  logic act_q;
  logic passed_q;
  logic [31:0] wcnt_q;
  logic use_filter;

  // Pins are asynchronous; the first stage feeds only the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= {cc_raw, gpi_raw};
      sync_q <= meta_q;
    end
  end

  always_comb begin
    case (tif.src)
      SRC_IN1: sel_raw = sync_q[0];
      SRC_IN2: sel_raw = sync_q[1];
      SRC_IN3: sel_raw = sync_q[2];
      SRC_IN4: sel_raw = sync_q[3];
      SRC_OR: sel_raw = tif.pol ? |sync_q[3:0] : &sync_q[3:0];
      SRC_CC1: sel_raw = sync_q[4];
      SRC_CC2: sel_raw = sync_q[5];
      SRC_CC3: sel_raw = sync_q[6];
      SRC_CC4: sel_raw = sync_q[7];
      default: sel_raw = 1'b0;
    endcase
  end

  // A software request is already active high; pins follow polarity.
  assign act = (tif.src == SRC_SOFT) ? soft_pulse :
               (tif.pol ? sel_raw : ~sel_raw);
  assign use_filter = tif.filt_en && (tif.src != SRC_SOFT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 1'b0;
      wcnt_q <= 32'h0;
      passed_q <= 1'b0;
      tif.fire <= 1'b0;
    end else begin
      act_q <= act;
      tif.fire <= 1'b0;
      if (act && !act_q) begin
        wcnt_q <= 32'h0;
        passed_q <= 1'b0;
        tif.fire <= !use_filter;
      end else if (act && use_filter && !passed_q && tif.us_tick) begin
        wcnt_q <= wcnt_q + 32'h1;
        // Pulses that end first never fire, so no frame follows.
        if (wcnt_q + 32'h1 >= tif.width_min) begin
          passed_q <= 1'b1;
          tif.fire <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tif.level <= 1'b0;
    end else begin
      tif.level <= act;
    end
  end
endmodule : ctf_trig_front

// ---- rtl/ctf_frame_ctrl.sv ----
// Camera trigger and frame control with APB register access.
module ctf_frame_ctrl
  import ctf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic general_input_one,
  input wire logic general_input_two,
  input wire logic general_input_three,
  input wire logic general_input_four,
  input wire logic [3:0] grabber_control,
  input wire logic [13:0] scene_level,
  output logic exposure_active,
  output logic video_active,
  output logic [3:0] setting_index,
  output logic [31:0] active_shutter_us,
  output logic defect_correction_enable,
  output logic [7:0] gain_code
);
  ctf_trig_if tif ();

  logic [11:0] ctrl_q;
  logic [7:0] src_q;
  logic [7:0] msc_src_q;
  logic [31:0] shutter_q;
  logic [31:0] delay_q;
  logic [31:0] wmin_q;
  logic [31:0] rate_q;
  logic [4:0] msc_cnt_q;
  logic [13:0] target_q;
  logic [31:0] readout_q;
  logic [31:0] table_q [16];
  logic [31:0] trig_tally_q;
  logic [31:0] frame_tally_q;
  logic [7:0] gain_q;
  logic soft_q;
  logic [6:0] div_q;
  logic us_tick_q;
  ctf_state_e state_q;
  logic [31:0] tcnt_q;
  logic [31:0] rcnt_q;
  logic rd_act_q;
  logic [3:0] idx_q;
  logic [4:0] bulk_left_q;
  logic [40:0] acc_q;
  logic fr_exp_q;
  logic fr_pend_q;

  logic wr_en;
  logic [1:0] msc_mode;
  logic msc_on;
  logic trig_mode;
  logic [31:0] cur_shutter;
  logic accept;
  logic exp_done;
  logic fr_start;
  logic fr_exp_done;
  logic rd_start;
  logic rd_done;
  logic token_ok;
  logic [63:0] rate_prod;
  logic [31:0] step;

  assign wr_en = psel && penable && pready && pwrite;
  assign msc_mode = ctrl_q[B_MSC_LO +: 2];
  assign msc_on = (msc_mode != MSC_OFF);
  assign trig_mode = ctrl_q[B_ACQ];
  assign cur_shutter = msc_on ? table_q[idx_q] : shutter_q;
  assign rate_prod = pwdata * readout_q;
  assign step = (shutter_q >> 3) + 32'h1;

  // Special triggering has its own source and polarity settings.
  assign tif.src = msc_on ? msc_src_q : src_q;
  assign tif.pol = msc_on ? ctrl_q[B_MSC_POL] : ctrl_q[B_POL];
  assign tif.filt_en = ctrl_q[B_FILT];
  assign tif.width_min = wmin_q;
  assign tif.us_tick = us_tick_q;

  ctf_trig_front u_front (
    .pclk(pclk),
    .presetn(presetn),
    .gpi_raw({general_input_four, general_input_three,
              general_input_two, general_input_one}),
    .cc_raw(grabber_control),
    .soft_pulse(soft_q),
    .tif(tif)
  );

  // One microsecond enable drives every timer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 7'h0;
      us_tick_q <= 1'b0;
    end else if (accept || (state_q == TS_DELAY && tcnt_q >= delay_q) ||
                 (state_q == TS_READOUT && !rd_act_q)) begin
      div_q <= 7'h0;
      us_tick_q <= 1'b0;
    end else begin
      us_tick_q <= (div_q == 7'(US_CYCLES - 1));
      div_q <= (div_q == 7'(US_CYCLES - 1)) ? 7'h0 : div_q + 7'h1;
    end
  end

  // Busy sequencer drops the request instead of queueing it.
  assign accept = (trig_mode || msc_on) && tif.fire &&
                  !ctrl_q[B_INH] && (state_q == TS_IDLE);
  assign exp_done = (state_q == TS_EXPOSE) &&
                    ((ctrl_q[B_EXPSRC] && !msc_on) ? !tif.level
                     : (us_tick_q && tcnt_q + 32'h1 >= cur_shutter));
  assign rd_done = rd_act_q && us_tick_q && (rcnt_q + 32'h1 >= readout_q);

  // With auto rate, free-run exposures run back to back and overlap the readout.
  assign token_ok = ctrl_q[B_AUTO] || (acc_q >= RATE_FULL);
  assign fr_start = !trig_mode && !msc_on && !fr_exp_q && !fr_pend_q &&
                    token_ok;
  assign fr_exp_done = fr_exp_q && us_tick_q &&
                       (tcnt_q + 32'h1 >= shutter_q);
  assign rd_start = (fr_pend_q && !rd_act_q) || exp_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TS_IDLE;
      tcnt_q <= 32'h0;
      fr_exp_q <= 1'b0;
      fr_pend_q <= 1'b0;
      bulk_left_q <= 5'h0;
    end else begin
      case (state_q)
        TS_IDLE: begin
          if (fr_start) begin
            fr_exp_q <= 1'b1;
            tcnt_q <= 32'h0;
          end else if (fr_exp_done) begin
            fr_exp_q <= 1'b0;
            fr_pend_q <= 1'b1;
          end else if (fr_exp_q && us_tick_q) begin
            tcnt_q <= tcnt_q + 32'h1;
          end
          if (fr_pend_q && !rd_act_q) begin
            fr_pend_q <= fr_exp_done;
          end
          if (accept) begin
            state_q <= TS_DELAY;
            tcnt_q <= 32'h0;
            bulk_left_q <= (msc_mode == MSC_BULK) ? msc_cnt_q : 5'h1;
          end
        end
        TS_DELAY: begin
          if (tcnt_q >= delay_q) begin
            state_q <= TS_EXPOSE;
            tcnt_q <= 32'h0;
          end else if (us_tick_q) begin
            tcnt_q <= tcnt_q + 32'h1;
          end
        end
        TS_EXPOSE: begin
          if (exp_done) begin
            state_q <= TS_READOUT;
            bulk_left_q <= bulk_left_q - 5'h1;
          end else if (us_tick_q) begin
            tcnt_q <= tcnt_q + 32'h1;
          end
        end
        TS_READOUT: begin
          // Next capture of a run starts only when output has ended.
          if (!rd_act_q) begin
            tcnt_q <= 32'h0;
            state_q <= (bulk_left_q != 5'h0) ? TS_EXPOSE : TS_IDLE;
          end
        end
        default: state_q <= TS_IDLE;
      endcase
      if (trig_mode || msc_on) begin
        fr_exp_q <= 1'b0;
        fr_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_act_q <= 1'b0;
      rcnt_q <= 32'h0;
    end else if (rd_start && !rd_act_q) begin
      rd_act_q <= 1'b1;
      rcnt_q <= 32'h0;
    end else if (rd_done) begin
      rd_act_q <= 1'b0;
    end else if (rd_act_q && us_tick_q) begin
      rcnt_q <= rcnt_q + 32'h1;
    end
  end

  // Rate tokens build up by the requested rate once per microsecond.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 41'h0;
    end else if (fr_start && !ctrl_q[B_AUTO]) begin
      acc_q <= acc_q - RATE_FULL;
    end else if (us_tick_q && acc_q < RATE_FULL) begin
      acc_q <= acc_q + {9'h0, rate_q};
    end
  end

  // The stored setting steps after each finished capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= 4'h0;
    end else if (!msc_on) begin
      idx_q <= 4'h0;
    end else if (exp_done) begin
      idx_q <= ({1'b0, idx_q} + 5'h1 >= msc_cnt_q) ? 4'h0 : idx_q + 4'h1;
    end
  end

  // A count event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_tally_q <= 32'h0;
    end else if (accept || fr_start) begin
      trig_tally_q <= (trig_tally_q >= TALLY_MAX) ? 32'h0
                      : trig_tally_q + 32'h1;
    end else if (wr_en && paddr == OFS_TRIG_TALLY && pwdata == 32'h0) begin
      trig_tally_q <= 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_tally_q <= 32'h0;
    end else if (rd_done) begin
      frame_tally_q <= (frame_tally_q >= TALLY_MAX) ? 32'h0
                       : frame_tally_q + 32'h1;
    end else if (wr_en && paddr == OFS_FRAME_TALLY && pwdata == 32'h0) begin
      frame_tally_q <= 32'h0;
    end
  end

  // Configuration writes; values outside their range are refused.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      src_q <= SRC_RST;
      msc_src_q <= SRC_RST;
      delay_q <= 32'h0;
      wmin_q <= WIDTH_MIN_LO;
      rate_q <= RATE_RST;
      msc_cnt_q <= MSC_MAX;
      target_q <= TARGET_RST;
      readout_q <= READOUT_RST;
      soft_q <= 1'b0;
    end else begin
      soft_q <= wr_en && paddr == OFS_SOFT && pwdata[0];
      if (wr_en) begin
        case (paddr)
          OFS_CTRL: begin
            ctrl_q <= pwdata[11:0];
            // With special triggering on, trigger mode cannot be entered.
            if (pwdata[B_MSC_LO +: 2] != MSC_OFF) begin
              ctrl_q[B_ACQ] <= 1'b0;
            end
            if (pwdata[B_MSC_LO +: 2] == 2'h3) begin
              ctrl_q[B_MSC_LO +: 2] <= msc_mode;
            end
          end
          OFS_SRC: begin
            src_q <= pwdata[7:0];
            msc_src_q <= pwdata[15:8];
          end
          OFS_DELAY: if (pwdata <= DELAY_MAX) delay_q <= pwdata;
          OFS_WIDTH_MIN: begin
            if (pwdata >= WIDTH_MIN_LO && pwdata <= WIDTH_MIN_HI) begin
              wmin_q <= pwdata;
            end
          end
          OFS_RATE: begin
            if (pwdata >= RATE_MIN &&
                rate_prod <= {23'h0, RATE_FULL}) begin
              rate_q <= pwdata;
            end
          end
          OFS_MSC_COUNT: begin
            if (pwdata != 32'h0 && pwdata <= {27'h0, MSC_MAX}) begin
              msc_cnt_q <= pwdata[4:0];
            end
          end
          OFS_TARGET: target_q <= pwdata[13:0];
          OFS_READOUT: if (pwdata != 32'h0) readout_q <= pwdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_en && paddr[7:6] == 2'h1 && paddr[1:0] == 2'h0 &&
        pwdata >= SHUTTER_MIN && pwdata <= SHUTTER_MAX) begin
      table_q[paddr[5:2]] <= pwdata;
    end
  end

  // Shutter shares software writes with the exposure loop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutter_q <= SHUTTER_RST;
      gain_q <= 8'h0;
    end else if (wr_en && paddr == OFS_SHUTTER) begin
      if (pwdata >= SHUTTER_MIN && pwdata <= SHUTTER_MAX) begin
        shutter_q <= pwdata;
      end
    end else if (wr_en && paddr == OFS_GAIN) begin
      gain_q <= pwdata[7:0];
    end else if (rd_done && scene_level < target_q) begin
      // Darkening stretches the shutter first, gain only at the limit.
      if (ctrl_q[B_CEXP] && shutter_q < SHUTTER_MAX) begin
        shutter_q <= (SHUTTER_MAX - shutter_q < step) ? SHUTTER_MAX
                     : shutter_q + step;
      end else if (ctrl_q[B_CGAIN] && gain_q < GAIN_MAX) begin
        gain_q <= gain_q + 8'h1;
      end
    end else if (rd_done && scene_level > target_q) begin
      if (ctrl_q[B_CGAIN] && gain_q != 8'h0) begin
        gain_q <= gain_q - 8'h1;
      end else if (ctrl_q[B_CEXP] && shutter_q > SHUTTER_MIN) begin
        shutter_q <= (shutter_q - SHUTTER_MIN < step) ? SHUTTER_MIN
                     : shutter_q - step;
      end
    end
  end

  // APB: data is set up in the setup phase, no wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable &&
                 (paddr[7] || paddr > OFS_GAIN && paddr < OFS_TABLE ||
                  paddr[1:0] != 2'h0);
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFS_CTRL: prdata <= {20'h0, ctrl_q};
          OFS_SRC: prdata <= {16'h0, msc_src_q, src_q};
          OFS_SHUTTER: prdata <= shutter_q;
          OFS_DELAY: prdata <= delay_q;
          OFS_WIDTH_MIN: prdata <= wmin_q;
          OFS_RATE: prdata <= rate_q;
          OFS_MSC_COUNT: prdata <= {27'h0, msc_cnt_q};
          OFS_TRIG_TALLY: prdata <= trig_tally_q;
          OFS_FRAME_TALLY: prdata <= frame_tally_q;
          OFS_STATUS: prdata <= {24'h0, idx_q, state_q, rd_act_q,
                                 fr_exp_q};
          OFS_TARGET: prdata <= {18'h0, target_q};
          OFS_READOUT: prdata <= readout_q;
          OFS_GAIN: prdata <= {24'h0, gain_q};
          default: prdata <= (paddr >= OFS_TABLE) ? table_q[paddr[5:2]]
                             : 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exposure_active <= 1'b0;
      video_active <= 1'b0;
      setting_index <= 4'h0;
      active_shutter_us <= SHUTTER_RST;
      defect_correction_enable <= 1'b0;
      gain_code <= 8'h0;
    end else begin
      exposure_active <= fr_exp_q || (state_q == TS_EXPOSE);
      video_active <= rd_act_q;
      setting_index <= idx_q;
      active_shutter_us <= cur_shutter;
      defect_correction_enable <= ctrl_q[B_DEFECT] && !msc_on;
      gain_code <= gain_q;
    end
  end
endmodule : ctf_frame_ctrl

// ---- tb/ctf_trig_src.sv ----
// Trigger source model driving the pulled-up trigger pins.
module ctf_trig_src #(
  parameter int GAP_CYC = 500000
) (
  input wire logic pclk,
  input wire logic video_active,
  input wire logic spaced,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int idle_n = GAP_CYC;
  // Pins rest high as the real inputs carry pull-ups.
  initial pin = 8'hff;
  always @(posedge pclk) begin
    if (spaced && video_active)
      idle_n <= 0;
    else if (idle_n < GAP_CYC)
      idle_n <= idle_n + 1;
  end
  task automatic pulse(input int ch, input int cyc);
    while (idle_n < GAP_CYC) @(posedge pclk);
    pin[ch] <= 1'b0;
    repeat (cyc) @(posedge pclk);
    pin[ch] <= 1'b1;
  endtask : pulse
endmodule : ctf_trig_src

// ---- tb/ctf_frame_ctrl_asserts.sv ----
// Port checks for the frame control block.
module ctf_frame_ctrl_asserts
  import ctf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic exposure_active,
  input wire logic video_active,
  input wire logic [3:0] setting_index,
  input wire logic [31:0] active_shutter_us,
  input wire logic defect_correction_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bad_a;
  // Holes at 0x38 and 0x3c sit between the main block and the table.
  assign bad_a = paddr[1:0] != 2'h0 || paddr[7] || paddr[7:3] == 5'h07;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad;
    s_setup ##0 bad_a;
  endsequence
  property p_rdy;
    s_setup |=> pready;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("no ready after setup");
  property p_acc;
    pready |-> psel && penable;
  endproperty
  a_acc: assert property (p_acc)
    else $error("ready outside access");
  property p_once;
    pready |=> !pready;
  endproperty
  a_once: assert property (p_once)
    else $error("ready held");
  property p_err;
    s_bad |=> pslverr;
  endproperty
  a_err: assert property (p_err)
    else $error("no error on bad address");
  property p_ok;
    s_setup ##0 !bad_a |=> !pslverr;
  endproperty
  a_ok: assert property (p_ok)
    else $error("error on mapped address");
  property p_shut;
    active_shutter_us >= SHUTTER_MIN && active_shutter_us <= SHUTTER_MAX;
  endproperty
  a_shut: assert property (p_shut)
    else $error("shutter out of range");
  property p_vid;
    $fell(exposure_active) |-> ##[0:3] video_active;
  endproperty
  a_vid: assert property (p_vid)
    else $error("no video after exposure");
  property p_dfc;
    setting_index != 4'h0 |-> !defect_correction_enable;
  endproperty
  a_dfc: assert property (p_dfc)
    else $error("defect correction in special");
endmodule : ctf_frame_ctrl_asserts
bind ctf_frame_ctrl ctf_frame_ctrl_asserts u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .exposure_active(exposure_active),
  .video_active(video_active), .setting_index(setting_index),
  .active_shutter_us(active_shutter_us),
  .defect_correction_enable(defect_correction_enable));

// ---- tb/ctf_frame_ctrl_tb.sv ----
// Self-checking bench for the camera trigger and frame control block.
module ctf_frame_ctrl_tb
  import ctf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic spaced = 0, pready, pslverr, exposure_active, video_active;
  logic dce;
  logic [7:0] paddr = 8'h00, pin;
  logic [31:0] pwdata = 32'h0, prdata, shut;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  logic [7:0] codes [9] = '{SRC_IN1, SRC_IN3, SRC_IN4, SRC_IN2, SRC_OR,
    SRC_CC1, SRC_CC2, SRC_CC3, SRC_CC4};
  int chs [9] = '{0, 2, 3, 1, 2, 4, 5, 6, 7};
  ctf_frame_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .general_input_one(pin[0]), .general_input_two(pin[1]),
    .general_input_three(pin[2]), .general_input_four(pin[3]),
    .grabber_control(pin[7:4]), .scene_level(14'h2c00),
    .exposure_active(exposure_active), .video_active(video_active),
    .setting_index(), .active_shutter_us(shut),
    .defect_correction_enable(dce), .gain_code());
  ctf_trig_src src (.pclk(pclk), .video_active(video_active),
    .spaced(spaced), .pin(pin));
  initial forever #5 pclk = ~pclk;
  task end_of_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] got);
    n_tests++;
    if (got !== x) begin
      $display("FAIL %s expected %h seen %h", nm, x, got);
      n_mismatch++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = pslverr ? 32'hbad0bad0 : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk($sformatf("reg %h", a), x, r);
  endtask : rd
  task automatic idle;
    for (int i = 0; i < 9000 && (exposure_active !== 1'b0 ||
         video_active !== 1'b0); i++) @(posedge pclk);
  endtask : idle
  task automatic shot(input int ch, input int wid, output int st,
                      output int len);
    st = 0;
    len = 0;
    if (ch >= 0) begin
      fork
        src.pulse(ch, wid);
      join_none
    end
    while (exposure_active !== 1'b1 && st < 4000) begin
      @(posedge pclk);
      st++;
    end
    while (exposure_active === 1'b1 && len < 9000) begin
      @(posedge pclk);
      len++;
    end
    repeat (3) @(posedge pclk);
    idle();
  endtask : shot
  initial begin
    logic [31:0] r;
    int st, len, st0;
    repeat (5) @(posedge pclk);
    chk("shutter", SHUTTER_RST, shut);
    presetn <= 1'b1;
    wr(OFS_READOUT, 32'ha);
    wr(OFS_SHUTTER, 32'ha);
    rd(OFS_CTRL, 32'h40);
    rd(OFS_SRC, 32'h0b0b);
    rd(OFS_WIDTH_MIN, WIDTH_MIN_LO);
    rd(OFS_MSC_COUNT, 32'h10);
    rd(OFS_TARGET, 32'h2c00);
    rd(8'h38, 32'hbad0bad0);
    wr(OFS_SHUTTER, 32'h9);
    rd(OFS_SHUTTER, 32'ha);
    wr(OFS_DELAY, 32'h003d0901);
    rd(OFS_DELAY, 32'h0);
    wr(OFS_RATE, 32'h0000f423);
    rd(OFS_RATE, RATE_RST);
    $display("test registers finished");
    repeat (3000) @(posedge pclk);
    apb(1'b0, OFS_FRAME_TALLY, 32'h0, r);
    chk("free frames", 1, r > 0 && r < 32'h100);
    apb(1'b0, OFS_TRIG_TALLY, 32'h0, r);
    chk("free triggers", 1, r > 0 && r < 32'h100);
    wr(OFS_SRC, 32'h0b04);
    wr(OFS_CTRL, 32'h41);
    idle();
    wr(OFS_TRIG_TALLY, 32'h0);
    wr(OFS_FRAME_TALLY, 32'h0);
    $display("test free-run finished");
    fork
      begin
        repeat (300) @(posedge pclk);
        src.pulse(0, 20);
      end
    join_none
    shot(0, 20, st0, len);
    chk("edge", 1, len > 990 && len < 1010);
    rd(OFS_TRIG_TALLY, 32'h1);
    rd(OFS_FRAME_TALLY, 32'h1);
    wr(OFS_DELAY, 32'h5);
    shot(0, 20, st, len);
    chk("delay", 1, st - st0 > 495 && st - st0 < 505);
    wr(OFS_DELAY, 32'h0);
    wr(OFS_CTRL, 32'h51);
    shot(0, 20, st, len);
    chk("inhibit", 0, len);
    wr(OFS_CTRL, 32'h43);
    shot(0, 500, st, len);
    chk("width", 1, len > 490 && len < 510);
    wr(OFS_WIDTH_MIN, 32'h14);
    wr(OFS_CTRL, 32'h61);
    shot(0, 1000, st, len);
    chk("short", 0, len);
    rd(OFS_TRIG_TALLY, 32'h3);
    shot(0, 2500, st, len);
    chk("filter", 1, st > 1905 && st < 2015);
    wr(OFS_SRC, 32'h0b00);
    wr(OFS_SOFT, 32'h1);
    shot(-1, 0, st, len);
    chk("soft", 1, len > 990 && len < 1010);
    wr(OFS_CTRL, 32'h41);
    for (int i = 0; i < 9; i++) begin
      wr(OFS_SRC, {24'h00000b, codes[i]});
      shot(chs[i], 20, st, len);
      chk("source", 1, len > 990 && len < 1010);
    end
    $display("test trigger finished");
    for (int i = 0; i < 3; i++) wr(OFS_TABLE + 8'(4 * i), 32'(10 * i + 10));
    wr(OFS_MSC_COUNT, 32'h3);
    wr(OFS_SRC, 32'h0b04);
    wr(OFS_CTRL, 32'h245);
    rd(OFS_CTRL, 32'h244);
    chk("defect", 0, dce);
    shot(0, 20, st, len);
    chk("own source", 0, len);
    wr(OFS_FRAME_TALLY, 32'h0);
    for (int i = 0; i < 3; i++) begin
      shot(i == 0 ? 1 : -1, 20, st, len);
      chk("bulk", 1, len / 100 == 10 * i + 10);
      chk("gap", 1, i == 0 || st > 0);
    end
    wr(OFS_CTRL, 32'h48);
    spaced <= 1'b1;
    wr(OFS_FRAME_TALLY, 32'h0);
    shot(1, 20, st, len);
    shot(-1, 0, st, len);
    rd(OFS_FRAME_TALLY, 32'h1);
    spaced <= 1'b0;
    $display("test special finished");
    end_of_test();
  end
endmodule : ctf_frame_ctrl_tb
